// ### design/exposure_seq_pkg.sv
// Constants, register map and carrier types of the exposure sequencer.
// Assumes a 125 MHz core clock; the internal line period is counted in that clock.
package exposure_seq_pkg;

    // Core clock and line period
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINE_PERIOD_NS = 58400;
    localparam int LINE_CYCLES = LINE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINE_TMR_W = 16;

    // Sequence lengths in line periods, and the highest shutter step
    localparam logic [10:0] FRAME_LINES = 11'h42C;
    localparam logic [10:0] DUMMY_LINES = 11'h036;
    localparam logic [10:0] ONE_LINE = 11'h001;
    localparam logic [9:0] EXPO_MIN = 10'h001;
    localparam logic [3:0] STEP_MAX = 4'h9;

    // Fixed shutter table, steps 9 down to 0, in line periods
    localparam logic [9:0][10:0] STEP_LINES = {
        11'h002, 11'h004, 11'h008, 11'h011, 11'h022,
        11'h044, 11'h0AB, 11'h11D, 11'h23A, FRAME_LINES
    };

    // Trigger mode codes
    localparam logic [2:0] TRIG_LONG = 3'h4;
    localparam logic [2:0] TRIG_START_STOP = 3'h5;
    localparam logic [2:0] TRIG_SMEARLESS = 3'h6;

    // Pixel clock half period in core cycles
    localparam logic [7:0] PIX_HALF = 8'h02;

    // Register byte addresses
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SHUTTER = 4'h4;
    localparam logic [3:0] REG_EXPOSURE = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // Control, shutter and exposure register field positions
    localparam int CTRL_TRIG_LSB = 0;
    localparam int CTRL_SHUT_MODE = 3;
    localparam int CTRL_STAT_SEL = 4;
    localparam int CTRL_TRIG_INV = 5;
    localparam int CTRL_WIN_INV = 6;
    localparam int CTRL_PIX_EN = 7;
    localparam int CTRL_EXT_LINE = 8;
    localparam int SHUT_STEP_LSB = 0;
    localparam int EXPO_CNT_LSB = 0;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT_LINE = 2'b01,
        SEQ_DUMMY = 2'b10,
        SEQ_EXPOSE = 2'b11
    } seq_state_t;

    typedef struct packed {
        logic [2:0] trigger_mode_select;
        logic shutter_mode_select;
        logic status_sel_window;
        logic trig_invert;
        logic window_invert;
        logic pixclk_en;
        logic ext_line_en;
        logic [3:0] shutter_speed_step;
        logic [9:0] programmable_exposure_count;
    } cfg_t;

    localparam cfg_t CFG_RST = '{
        trigger_mode_select: 3'h0,
        shutter_mode_select: 1'b0,
        status_sel_window: 1'b0,
        trig_invert: 1'b0,
        window_invert: 1'b0,
        pixclk_en: 1'b0,
        ext_line_en: 1'b0,
        shutter_speed_step: 4'h0,
        programmable_exposure_count: 10'h001
    };

    typedef struct packed {
        logic exposure_active_flag;
        logic readout_window_n;
        logic status_pin;
        logic frame_sync_out;
        logic pixel_clk_out;
    } pins_out_t;

endpackage

// ### design/pin_sync_edge.sv
// Two-flop synchroniser with optional inversion and rising-edge detect.
// Assumes an asynchronous pin; invert is a level on the core clock.
`timescale 1ns/10ps
`default_nettype none
module pin_sync_edge (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Pin and sense
    input wire logic i_pin,
    input wire logic i_invert,
    // Synchronised result
    output logic o_level,
    output logic o_rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } sync_st_t;

    sync_st_t cur;
    sync_st_t nxt;

    always_comb begin
        nxt = cur;
        nxt.meta = i_pin;
        nxt.sync = cur.meta;
        nxt.prev = cur.sync ^ i_invert;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign o_level = cur.sync ^ i_invert;
    assign o_rise = o_level & ~cur.prev;
endmodule
`default_nettype wire

// ### design/triggered_exposure_sequencer.sv
// Triggered exposure and readout sequencer with Avalon-MM registers.
// Assumes async trigger, line-sync and frame-sync pins; 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module triggered_exposure_sequencer #(
    parameter int P_LINE_CYCLES = exposure_seq_pkg::LINE_CYCLES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Avalon-MM slave
    input wire logic [exposure_seq_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Camera pins in
    input wire logic i_trigger,
    input wire logic i_line_sync,
    input wire logic i_frame_sync,
    // Camera pins out
    output logic o_exposure_active_flag,
    output logic o_readout_window_n,
    output logic o_status_pin,
    output logic o_frame_sync_out,
    output logic o_pixel_clk_out
);
    typedef struct packed {
        exposure_seq_pkg::seq_state_t seq;
        logic [10:0] cnt;
        logic [10:0] rd_cnt;
        logic [exposure_seq_pkg::LINE_TMR_W-1:0] line_tmr;
        logic [7:0] pix_div;
        logic pix_raw;
        exposure_seq_pkg::cfg_t cfg;
        logic ack;
        logic [31:0] rdata;
        exposure_seq_pkg::pins_out_t pins;
    } seq_st_t;

    seq_st_t cur;
    seq_st_t nxt;

    logic trig_rise;
    logic line_rise;
    logic frame_rise;
    logic line_tick;
    logic req;
    logic start_rd;
    logic [2:0] mode;
    logic [10:0] exp_lines;
    logic [3:0] step_idx;

    pin_sync_edge u_trig_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin(i_trigger),
        .i_invert(cur.cfg.trig_invert),
        .o_level(),
        .o_rise(trig_rise)
    );

    pin_sync_edge u_line_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin(i_line_sync),
        .i_invert(1'b0),
        .o_level(),
        .o_rise(line_rise)
    );

    pin_sync_edge u_frame_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin(i_frame_sync),
        .i_invert(1'b0),
        .o_level(),
        .o_rise(frame_rise)
    );

    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~cur.ack;
    assign mode = cur.cfg.trigger_mode_select;

    always_comb begin
        nxt = cur;
        start_rd = 1'b0;
        step_idx = cur.cfg.shutter_speed_step;
        // Steps above the table saturate at the shortest fixed shutter
        if (step_idx > exposure_seq_pkg::STEP_MAX) begin
            step_idx = exposure_seq_pkg::STEP_MAX;
        end
        if (cur.cfg.shutter_mode_select) begin
            exp_lines = {1'b0, cur.cfg.programmable_exposure_count};
            if (cur.cfg.programmable_exposure_count <
                exposure_seq_pkg::EXPO_MIN) begin
                exp_lines = exposure_seq_pkg::ONE_LINE;
            end
        end else begin
            exp_lines = exposure_seq_pkg::STEP_LINES[step_idx];
        end

        // Line timing: internal period or external line sync
        line_tick = 1'b0;
        if (cur.line_tmr == 16'(P_LINE_CYCLES - 1)) begin
            nxt.line_tmr = '0;
            line_tick = ~cur.cfg.ext_line_en;
        end else begin
            nxt.line_tmr = cur.line_tmr + 16'h0001;
        end
        if (cur.cfg.ext_line_en && line_rise) begin
            nxt.line_tmr = '0;
            line_tick = 1'b1;
        end

        // Exposure sequence
        case (cur.seq)
            exposure_seq_pkg::SEQ_IDLE: begin
                if (mode == exposure_seq_pkg::TRIG_LONG && frame_rise) begin
                    nxt.seq = exposure_seq_pkg::SEQ_EXPOSE;
                    nxt.line_tmr = '0;
                end else if (trig_rise && cur.rd_cnt == '0) begin
                    if (mode == exposure_seq_pkg::TRIG_START_STOP) begin
                        nxt.seq = exposure_seq_pkg::SEQ_WAIT_LINE;
                    end else if (mode == exposure_seq_pkg::TRIG_SMEARLESS)
                    begin
                        nxt.seq = exposure_seq_pkg::SEQ_DUMMY;
                        nxt.cnt = exposure_seq_pkg::DUMMY_LINES;
                    end
                end
            end
            exposure_seq_pkg::SEQ_WAIT_LINE: begin
                if (line_tick) begin
                    nxt.seq = exposure_seq_pkg::SEQ_EXPOSE;
                end
            end
            exposure_seq_pkg::SEQ_DUMMY: begin
                if (line_tick) begin
                    if (cur.cnt == exposure_seq_pkg::ONE_LINE) begin
                        nxt.seq = exposure_seq_pkg::SEQ_EXPOSE;
                        nxt.cnt = exp_lines;
                    end else begin
                        nxt.cnt = cur.cnt - exposure_seq_pkg::ONE_LINE;
                    end
                end
            end
            exposure_seq_pkg::SEQ_EXPOSE: begin
                if (mode == exposure_seq_pkg::TRIG_START_STOP) begin
                    if (frame_rise) begin
                        nxt.seq = exposure_seq_pkg::SEQ_IDLE;
                        start_rd = 1'b1;
                    end
                end else if (mode == exposure_seq_pkg::TRIG_SMEARLESS) begin
                    if (line_tick) begin
                        if (cur.cnt == exposure_seq_pkg::ONE_LINE) begin
                            nxt.seq = exposure_seq_pkg::SEQ_IDLE;
                            start_rd = 1'b1;
                        end else begin
                            nxt.cnt = cur.cnt - exposure_seq_pkg::ONE_LINE;
                        end
                    end
                end else if (mode == exposure_seq_pkg::TRIG_LONG) begin
                    // Each frame sync closes one exposure and opens the next
                    if (frame_rise) begin
                        start_rd = 1'b1;
                        nxt.line_tmr = '0;
                    end
                end else begin
                    nxt.seq = exposure_seq_pkg::SEQ_IDLE;
                end
            end
            default: begin
                nxt.seq = exposure_seq_pkg::SEQ_IDLE;
            end
        endcase
        if (cur.seq != exposure_seq_pkg::SEQ_IDLE &&
            mode != exposure_seq_pkg::TRIG_LONG &&
            mode != exposure_seq_pkg::TRIG_START_STOP &&
            mode != exposure_seq_pkg::TRIG_SMEARLESS) begin
            nxt.seq = exposure_seq_pkg::SEQ_IDLE;
        end

        // Readout of one frame, counted in line ticks
        if (start_rd) begin
            nxt.rd_cnt = exposure_seq_pkg::FRAME_LINES;
        end else if (cur.rd_cnt != '0 && line_tick) begin
            nxt.rd_cnt = cur.rd_cnt - exposure_seq_pkg::ONE_LINE;
        end

        // Pixel clock from a divider enable
        if (cur.pix_div == exposure_seq_pkg::PIX_HALF - 8'h01) begin
            nxt.pix_div = '0;
            nxt.pix_raw = ~cur.pix_raw;
        end else begin
            nxt.pix_div = cur.pix_div + 8'h01;
        end

        // Avalon-MM: one wait cycle, then the answer
        nxt.ack = req & ~cur.ack;
        if (i_avs_read && !cur.ack) begin
            if (i_avs_address == exposure_seq_pkg::REG_CTRL) begin
                nxt.rdata = {23'h000000, cur.cfg.ext_line_en,
                    cur.cfg.pixclk_en, cur.cfg.window_invert,
                    cur.cfg.trig_invert, cur.cfg.status_sel_window,
                    cur.cfg.shutter_mode_select,
                    cur.cfg.trigger_mode_select};
            end else if (i_avs_address == exposure_seq_pkg::REG_SHUTTER) begin
                nxt.rdata = {28'h0000000, cur.cfg.shutter_speed_step};
            end else if (i_avs_address == exposure_seq_pkg::REG_EXPOSURE)
            begin
                nxt.rdata = {22'h000000,
                    cur.cfg.programmable_exposure_count};
            end else if (i_avs_address == exposure_seq_pkg::REG_STATUS) begin
                nxt.rdata = {6'h00, cur.cnt, cur.rd_cnt, 1'b0,
                    cur.pins.exposure_active_flag, cur.seq};
            end else begin
                nxt.rdata = '0;
            end
        end
        if (i_avs_write && cur.ack) begin
            if (i_avs_address == exposure_seq_pkg::REG_CTRL) begin
                nxt.cfg.trigger_mode_select =
                    i_avs_writedata[exposure_seq_pkg::CTRL_TRIG_LSB +: 3];
                nxt.cfg.shutter_mode_select =
                    i_avs_writedata[exposure_seq_pkg::CTRL_SHUT_MODE];
                nxt.cfg.status_sel_window =
                    i_avs_writedata[exposure_seq_pkg::CTRL_STAT_SEL];
                nxt.cfg.trig_invert =
                    i_avs_writedata[exposure_seq_pkg::CTRL_TRIG_INV];
                nxt.cfg.window_invert =
                    i_avs_writedata[exposure_seq_pkg::CTRL_WIN_INV];
                nxt.cfg.pixclk_en =
                    i_avs_writedata[exposure_seq_pkg::CTRL_PIX_EN];
                nxt.cfg.ext_line_en =
                    i_avs_writedata[exposure_seq_pkg::CTRL_EXT_LINE];
            end else if (i_avs_address == exposure_seq_pkg::REG_SHUTTER) begin
                nxt.cfg.shutter_speed_step =
                    i_avs_writedata[exposure_seq_pkg::SHUT_STEP_LSB +: 4];
            end else if (i_avs_address == exposure_seq_pkg::REG_EXPOSURE)
            begin
                nxt.cfg.programmable_exposure_count =
                    i_avs_writedata[exposure_seq_pkg::EXPO_CNT_LSB +: 10];
            end
        end

        // Registered pin outputs, taken from the next state
        nxt.pins.exposure_active_flag =
            (nxt.seq == exposure_seq_pkg::SEQ_EXPOSE);
        nxt.pins.readout_window_n =
            (nxt.rd_cnt == '0) ^ cur.cfg.window_invert;
        nxt.pins.status_pin = cur.cfg.status_sel_window ?
            nxt.pins.readout_window_n :
            nxt.pins.exposure_active_flag;
        nxt.pins.frame_sync_out = start_rd;
        nxt.pins.pixel_clk_out = nxt.pix_raw & cur.cfg.pixclk_en;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cur <= '0;
            cur.cfg <= exposure_seq_pkg::CFG_RST;
            cur.pins.readout_window_n <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    assign o_avs_readdata = cur.rdata;
    assign o_exposure_active_flag = cur.pins.exposure_active_flag;
    assign o_readout_window_n = cur.pins.readout_window_n;
    assign o_status_pin = cur.pins.status_pin;
    assign o_frame_sync_out = cur.pins.frame_sync_out;
    assign o_pixel_clk_out = cur.pins.pixel_clk_out;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    AST_READOUT_LEN: assert property (
        $rose(cur.rd_cnt != '0)
        |-> cur.rd_cnt == exposure_seq_pkg::FRAME_LINES
    ) else $error("readout did not start at one frame of lines");
    AST_SS_START: assert property (
        cur.seq == exposure_seq_pkg::SEQ_WAIT_LINE && line_tick &&
        mode == exposure_seq_pkg::TRIG_START_STOP
        |=> o_exposure_active_flag
    ) else $error("start/stop exposure missed the line tick");
    AST_SS_STOP: assert property (
        cur.seq == exposure_seq_pkg::SEQ_EXPOSE && frame_rise &&
        mode == exposure_seq_pkg::TRIG_START_STOP
        |=> !o_exposure_active_flag && o_frame_sync_out
            && cur.rd_cnt != '0
    ) else $error("start/stop exposure did not stop on frame sync");
    AST_FS_ONLY_AFTER: assert property (
        o_frame_sync_out |-> $past(cur.seq) == exposure_seq_pkg::SEQ_EXPOSE
    ) else $error("frame sync out without an exposure");
    AST_SMEAR_DUMMY: assert property (
        $rose(o_exposure_active_flag) &&
        mode == exposure_seq_pkg::TRIG_SMEARLESS
        |-> $past(cur.seq) == exposure_seq_pkg::SEQ_DUMMY
            && $past(cur.cnt) == exposure_seq_pkg::ONE_LINE
    ) else $error("smearless exposure began before the dummy readout");
    AST_IGNORE_BUSY: assert property (
        cur.seq == exposure_seq_pkg::SEQ_IDLE && trig_rise &&
        cur.rd_cnt != '0 |=> cur.seq == exposure_seq_pkg::SEQ_IDLE
    ) else $error("trigger accepted during readout");
    AST_STATUS_SEL: assert property (
        ##1 o_status_pin == ($past(cur.cfg.status_sel_window) ?
            o_readout_window_n : o_exposure_active_flag)
    ) else $error("status pin carries the wrong signal");
    AST_LONG_RESTART: assert property (
        mode == exposure_seq_pkg::TRIG_LONG && frame_rise &&
        cur.seq == exposure_seq_pkg::SEQ_EXPOSE
        |=> o_exposure_active_flag
            && cur.rd_cnt == exposure_seq_pkg::FRAME_LINES
            && cur.line_tmr == '0
    ) else $error("long exposure frame sync did not restart");
    AST_PIXCLK_OFF: assert property (
        !cur.cfg.pixclk_en [*2] |-> !o_pixel_clk_out
    ) else $error("pixel clock toggles while disabled");
    AST_BUS_ANSWER: assert property (
        req && o_avs_waitrequest |=> !o_avs_waitrequest
    ) else $error("bus request not answered in one cycle");
endmodule
`default_nettype wire

// ### testbench/sync_source.sv
// Trigger source and line/frame sync generator facing the camera pins.
// Assumes its tasks are called right after a rising core clock edge.
`timescale 1ns/10ps
`default_nettype none
module sync_source (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Trigger rest level
    input wire logic i_trig_idle,
    // Camera pins
    output logic o_trigger,
    output logic o_line_sync,
    output var logic o_frame_sync
);
    logic [2:0] phase_ff;
    logic trig_act = 1'b0;
    initial o_frame_sync = 1'b0;
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase_ff <= 3'h0;
        end else begin
            phase_ff <= phase_ff + 3'h1;
        end
    end
    // Line sync every 8 core cycles, half high
    assign o_line_sync = phase_ff[2];
    assign o_trigger = i_trig_idle ^ trig_act;
    // Trigger held a whole number of lines, 8 core cycles each
    task automatic pulse_trigger(input int lines);
        trig_act <= 1'b1;
        repeat (lines * 8) @(posedge i_core_clk);
        trig_act <= 1'b0;
    endtask
    task automatic pulse_frame();
        o_frame_sync <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_frame_sync <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Bench for the exposure sequencer: registers, start/stop, smearless, long.
// Assumes the source model gives external line sync of 8 core cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct {
        logic wr;
        logic [3:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
    } row_t;
    localparam int LP = 8;
    localparam int FR = 1068 * LP;
    logic core_clk;
    logic rst_n;
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic waitreq;
    logic flag;
    logic win_n;
    logic stat;
    logic fs_out;
    logic pix;
    logic trig;
    logic line;
    logic frame;
    logic trig_idle;
    int mismatches = 0;
    int total_checks = 0;
    int fs_count = 0;
    int n;
    int t0;
    row_t rows [7] = '{
        '{1'b0, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0},
        '{1'b0, 4'h4, 32'h0, 32'hFFFF_FFFF, 32'h0},
        '{1'b0, 4'h8, 32'h0, 32'hFFFF_FFFF, 32'h1},
        '{1'b1, 4'h4, 32'h7, 32'hFFFF_FFFF, 32'h7},
        '{1'b1, 4'h8, 32'h3FF, 32'hFFFF_FFFF, 32'h3FF},
        '{1'b1, 4'h2, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0},
        '{1'b1, 4'hC, 32'hFFFF_FFFF, 32'hF, 32'h0}
    };
    triggered_exposure_sequencer #(.P_LINE_CYCLES(20))
        i_triggered_exposure_sequencer (
        .i_core_clk(core_clk), .i_rstn(rst_n), .i_avs_address(address),
        .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
        .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
        .i_trigger(trig), .i_line_sync(line), .i_frame_sync(frame),
        .o_exposure_active_flag(flag), .o_readout_window_n(win_n),
        .o_status_pin(stat), .o_frame_sync_out(fs_out),
        .o_pixel_clk_out(pix));
    sync_source i_sync_source (
        .i_core_clk(core_clk), .i_rstn(rst_n), .i_trig_idle(trig_idle),
        .o_trigger(trig), .o_line_sync(line), .o_frame_sync(frame));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (fs_out === 1'b1) begin
            fs_count++;
        end
    end
    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
            input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        // Sample the answer at the rising edge, before it updates
        do begin
            @(posedge core_clk);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        rd = readdata;
        check(k < 50, "bus answer missing");
        read <= 1'b0;
        write <= 1'b0;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return flag;
            1: return win_n;
            default: return fs_out;
        endcase
    endfunction
    task automatic wait_lvl(input int sel, input logic v, input int lim);
        n = 0;
        while (pick(sel) !== v && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        check(n < lim, "output wait timed out");
    endtask
    task automatic smear(input logic [31:0] ctrl, input logic [31:0] shut,
            input logic [31:0] expo, input int lines);
        bus(1'b1, 4'h0, 32'h0000_0100);
        trig_idle <= ctrl[5];
        bus(1'b1, 4'h4, shut);
        bus(1'b1, 4'h8, expo);
        bus(1'b1, 4'h0, ctrl);
        @(posedge core_clk);
        fork
            i_sync_source.pulse_trigger(3);
        join_none
        wait_lvl(0, 1'b1, 700);
        check(n >= 53 * LP && n <= 55 * LP, "dummy readout");
        wait_lvl(0, 1'b0, FR);
        check(n >= lines * LP - 1 && n <= lines * LP + 1, "shutter");
        check(win_n === 1'b0, "no readout after exposure");
        wait_lvl(1, 1'b1, FR + 100);
    endtask
    task automatic pix_count(input int want);
        logic last;
        int k;
        k = 0;
        repeat (3) @(negedge core_clk);
        last = pix;
        repeat (16) begin
            @(negedge core_clk);
            if (pix !== last) begin
                k++;
            end
            last = pix;
        end
        check(k == want, "pixel clock toggles");
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        trig_idle = 1'b0;
        rst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        check(win_n === 1'b1 && flag === 1'b0 && pix === 1'b0, "reset pins");
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                bus(1'b1, rows[i].a, rows[i].d);
            end
            bus(1'b0, rows[i].a, 32'h0);
            check((rd & rows[i].m) === rows[i].e, "register");
        end
        bus(1'b1, 4'h0, 32'h0000_0105);
        @(posedge core_clk);
        fork
            i_sync_source.pulse_trigger(3);
        join_none
        wait_lvl(0, 1'b1, 40);
        check(n >= 4 && n <= LP + 6, "exposure start");
        @(negedge core_clk);
        check(stat === 1'b1, "status pin shows exposure");
        repeat (10 * LP) @(negedge core_clk);
        check(flag === 1'b1, "exposure ended early");
        @(posedge core_clk);
        fork
            i_sync_source.pulse_frame();
        join_none
        wait_lvl(2, 1'b1, 20);
        t0 = int'($time);
        check(n <= 6 && flag === 1'b0 && win_n === 1'b0, "stop");
        @(posedge core_clk);
        fork
            i_sync_source.pulse_trigger(3);
        join_none
        bus(1'b1, 4'h0, 32'h0000_0115);
        repeat (40) @(negedge core_clk);
        check(flag === 1'b0 && stat === win_n, "busy trigger");
        wait_lvl(1, 1'b1, FR + 100);
        t0 = (int'($time) - t0) / 8;
        check(t0 >= FR - LP && t0 <= FR + LP, "readout length");
        smear(32'h0000_012E, 32'h0, 32'h3FF, 1023);
        smear(32'h0000_0106, 32'h9, 32'h1, 2);
        smear(32'h0000_0106, 32'hF, 32'h1, 2);
        bus(1'b1, 4'h0, 32'h0000_0104);
        t0 = fs_count;
        @(posedge core_clk);
        fork
            begin
                i_sync_source.pulse_frame();
                repeat (FR - 4) @(posedge core_clk);
                i_sync_source.pulse_frame();
            end
        join_none
        wait_lvl(0, 1'b1, 20);
        check(n <= 8 && fs_count == t0, "long exposure start");
        wait_lvl(2, 1'b1, FR + 40);
        check(n >= FR - 40 && flag === 1'b1, "long readout");
        wait_lvl(1, 1'b1, FR + 100);
        bus(1'b1, 4'h0, 32'h0000_00C0);
        repeat (3) @(negedge core_clk);
        check(win_n === 1'b0 && flag === 1'b0, "window inverted");
        pix_count(8);
        bus(1'b1, 4'h0, 32'h0);
        pix_count(0);
        check(fs_count == 5, "frame sync count");
        wrap_up();
    end
endmodule
`default_nettype wire
